// File: verilog/pcs_pkg.sv
/*
 * Shared constants and types of the PWM clock control and scaler block.
 * Assumes one 50 MHz system clock and a plain strobe register port.
 */
package pcs_pkg;

    // ==========================================================
    // Register offsets (word index on the plain port)
    // ==========================================================
    localparam logic [3:0] PCS_OFS_CLKCON  = 4'h0; // Clock control
    localparam logic [3:0] PCS_OFS_STEP    = 4'h1; // Scale increment
    localparam logic [3:0] PCS_OFS_MINPER  = 4'h2; // Minimum period
    localparam logic [3:0] PCS_OFS_UNLOCK  = 4'h3; // Unlock key port
    localparam logic [3:0] PCS_OFS_IRQSTAT = 4'h4; // Sticky events, RO
    localparam logic [3:0] PCS_OFS_IRQCLR  = 4'h5; // Clear, WO
    localparam logic [3:0] PCS_OFS_IRQEN   = 4'h6; // Enable mask
    localparam logic [3:0] PCS_OFS_STATUS  = 4'h7; // Live status, RO

    // ==========================================================
    // Clock control field positions
    // ==========================================================
    localparam int PCS_BIT_READY   = 15;
    localparam int PCS_BIT_ERROR   = 14;
    localparam int PCS_BIT_LOCK    = 8;
    localparam int PCS_POS_DIV     = 4;
    localparam int PCS_POS_SRC     = 0;

    // Writable bits of the clock control register
    localparam logic [15:0] PCS_CLKCON_WMASK = 16'h0133;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] PCS_RST_CLKCON = 16'h0000;
    localparam logic [15:0] PCS_RST_STEP   = 16'h0000;
    localparam logic [15:0] PCS_RST_MINPER = 16'h0000;
    localparam logic [2:0]  PCS_RST_IRQEN  = 3'h0;

    // ==========================================================
    // Unlock keys, arbitrary values
    // ==========================================================
    localparam logic [15:0] PCS_KEY_FIRST  = 16'h55AA;
    localparam logic [15:0] PCS_KEY_SECOND = 16'hAA55;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int PCS_CLK_MHZ       = 50;
    localparam int PCS_CAL_TIME_US   = 10; // Fine-edge calibration time
    localparam int PCS_CAL_CYCLES    = PCS_CAL_TIME_US * PCS_CLK_MHZ;

    // Interrupt event bits
    localparam int PCS_EV_READY  = 0;
    localparam int PCS_EV_ERROR  = 1;
    localparam int PCS_EV_PULSE  = 2;

    // Master clock source codes
    typedef enum logic [1:0] {
        PCS_SRC_SYSOSC  = 2'h0,
        PCS_SRC_AUXVCO2 = 2'h1,
        PCS_SRC_PRIPLL  = 2'h2,
        PCS_SRC_AUXPLL  = 2'h3
    } pcs_src_t;

    // Register port bundle
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pcs_req_t;

endpackage

// File: verilog/pcs_scaler.sv
/*
 * Frequency-scaling accumulator of the PWM clock front end.
 * Assumes step and minimum period are stable register outputs.
 */
module pcs_scaler
    import pcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tick,      // One master clock cycle
    input  wire logic [15:0] step,
    input  wire logic [15:0] min_per,
    output logic             pulse_q
);

    // ==========================================================
    // Accumulator
    // ==========================================================
    logic [16:0] acc_q;   // One spare bit so a sum never wraps while step is at most the minimum period
    logic [16:0] sum;     // Accumulator plus step

    assign sum = acc_q + {1'b0, step};

    // Add on every tick, wrap by the minimum period on a pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q   <= 17'h00000;
            pulse_q <= 1'b0;
        end else if (tick) begin
            if (sum > {1'b0, min_per}) begin
                // Keep the remainder for rate accuracy
                acc_q   <= sum - {1'b0, min_per};
                pulse_q <= 1'b1;
            end else begin
                acc_q   <= sum;
                pulse_q <= 1'b0;
            end
        end else begin
            pulse_q <= 1'b0;
        end
    end

    // One pulse only on a tick that exceeds the threshold
    pulse_cause_a: assert property (@(posedge clk) disable iff (rst)
        pulse_q |-> $past(tick) && $past(sum) > {1'b0, $past(min_per)})
        else $error("scaled pulse without threshold crossing");

    // After a pulse the accumulator holds the sum less the minimum period
    acc_carry_a: assert property (@(posedge clk) disable iff (rst)
        pulse_q |-> acc_q == $past(sum) - {1'b0, $past(min_per)})
        else $error("accumulator remainder wrong");

endmodule

// File: verilog/pcs_top.sv
/*
 * PWM clock control and frequency scaler: registers, lock,
 * clock source and divider selection, fine-edge status, interrupts.
 * Assumes the four master clock sources arrive as enable ticks in the
 * system clock domain, and fine-edge status arrives synchronous.
 */
// Local design decisions: the strobed register port and the register addresses.
// Contract
// - Ready bit shows fine-edge circuitry is ready.
// - Error bit sets on fault; reduced resolution.
// - Full resolution only ready and no error.
// - Lock bit blocks protected writes when set.
// - Lock clears only after unlock sequence.
// - Divider field 5-4 selects 2/4/8/16.
// - Source field 1-0 selects master clock.
// - Step added to accumulator each master tick.
// - Pulse emitted when accumulator exceeds minimum.
// - Unimplemented control bits read zero.
// - Sixteen-bit minimum period register.
module pcs_top
    import pcs_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        SRC_SYSOSC_TICK,   // Master clock ticks
    input  wire logic        SRC_AUXVCO2_TICK,
    input  wire logic        SRC_PRIPLL_TICK,
    input  wire logic        SRC_AUXPLL_TICK,
    input  wire logic        HIRES_CAL_DONE,    // Calibration finished
    input  wire logic        HIRES_FAULT,       // Fine-edge fault pulse
    input  wire logic        GEN_ANY_ON,        // Any generator enabled
    output logic             MASTER_TICK,       // Selected master tick
    output logic             PWM_CLK_TICK,      // Divided master tick
    output logic             SCALED_PULSE,      // Scaler output pulse
    output logic             FULL_RES,          // Fine edges usable
    output logic             IRQ
);

    // ==========================================================
    // Register port
    // ==========================================================
    pcs_req_t req;           // Bundled request
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic        lock_q;          // Protection lock
    logic [1:0]  div_sel_q;       // Clock divider select
    pcs_src_t    src_q;           // Master clock source
    logic        ready_q;         // Fine-edge ready
    logic        error_q;         // Fine-edge error, sticky
    logic [15:0] step_q;          // Frequency scale increment
    logic [15:0] min_per_q;       // Frequency scale minimum period
    logic [2:0]  irq_stat_q;      // Sticky events
    logic [2:0]  irq_en_q;        // Event enables
    logic        src_chg_run_q;   // Source changed while running
    logic        wr_clkcon;       // Control write strobe
    logic        unlock_ok;       // Unlock sequence complete

    assign wr_clkcon = req.wr && req.addr == PCS_OFS_CLKCON;

    // ==========================================================
    // Unlock sequencer
    // ==========================================================
    typedef enum logic [1:0] {
        PCS_UL_IDLE  = 2'b00,
        PCS_UL_KEY1  = 2'b01,
        PCS_UL_OPEN  = 2'b11
    } pcs_ul_t;

    pcs_ul_t ul_q;   // Progress through the key sequence

    assign unlock_ok = ul_q == PCS_UL_OPEN;

    // Two keys back to back on the unlock port arm one lock clear;
    // any other write in between aborts, so stray code cannot unlock
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ul_q <= PCS_UL_IDLE;
        end else if (req.wr) begin
            unique case (ul_q)
                PCS_UL_IDLE: begin
                    if (req.addr == PCS_OFS_UNLOCK &&
                        req.wdata == PCS_KEY_FIRST) begin
                        ul_q <= PCS_UL_KEY1;
                    end
                end
                PCS_UL_KEY1: begin
                    if (req.addr == PCS_OFS_UNLOCK &&
                        req.wdata == PCS_KEY_SECOND) begin
                        ul_q <= PCS_UL_OPEN;
                    end else begin
                        ul_q <= PCS_UL_IDLE;
                    end
                end
                PCS_UL_OPEN: begin
                    // Any write consumes the open window
                    ul_q <= PCS_UL_IDLE;
                end
                default: begin
                    ul_q <= PCS_UL_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Clock control register
    // ==========================================================
    // Lock sets freely; clearing needs the open window
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            lock_q <= PCS_RST_CLKCON[PCS_BIT_LOCK];
        end else if (wr_clkcon) begin
            if (req.wdata[PCS_BIT_LOCK]) begin
                lock_q <= 1'b1;
            end else if (unlock_ok) begin
                lock_q <= 1'b0;
            end
        end
    end

    // Divider and source are protected fields
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            div_sel_q <= PCS_RST_CLKCON[PCS_POS_DIV +: 2];
            src_q     <= pcs_src_t'(PCS_RST_CLKCON[PCS_POS_SRC +: 2]);
        end else if (wr_clkcon && !lock_q) begin
            div_sel_q <= req.wdata[PCS_POS_DIV +: 2];
            src_q     <= pcs_src_t'(req.wdata[PCS_POS_SRC +: 2]);
        end
    end

    // Flag a source change while generators run; software should not
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            src_chg_run_q <= 1'b0;
        end else begin
            src_chg_run_q <= wr_clkcon && !lock_q && GEN_ANY_ON &&
                req.wdata[PCS_POS_SRC +: 2] != src_q;
        end
    end

    // ==========================================================
    // Scaler registers, also lock protected
    // ==========================================================
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            step_q    <= PCS_RST_STEP;
            min_per_q <= PCS_RST_MINPER;
        end else if (req.wr && !lock_q) begin
            if (req.addr == PCS_OFS_STEP) begin
                step_q <= req.wdata;
            end
            if (req.addr == PCS_OFS_MINPER) begin
                min_per_q <= req.wdata;
            end
        end
    end

    // ==========================================================
    // Fine-edge status
    // ==========================================================
    // Ready follows calibration; error holds until reset
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ready_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            ready_q <= HIRES_CAL_DONE;
            if (HIRES_FAULT) begin
                error_q <= 1'b1;
            end
        end
    end

    // Full resolution only while ready and fault free
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            FULL_RES <= 1'b0;
        end else begin
            FULL_RES <= ready_q && !error_q;
        end
    end

    // ==========================================================
    // Master clock select and divider
    // ==========================================================
    logic       sel_tick;   // Tick of the selected source
    logic [3:0] div_cnt_q;  // Divider count
    logic [3:0] div_top;    // Last count before wrap

    always_comb begin
        unique case (src_q)
            PCS_SRC_SYSOSC:  sel_tick = SRC_SYSOSC_TICK;
            PCS_SRC_AUXVCO2: sel_tick = SRC_AUXVCO2_TICK;
            PCS_SRC_PRIPLL:  sel_tick = SRC_PRIPLL_TICK;
            PCS_SRC_AUXPLL:  sel_tick = SRC_AUXPLL_TICK;
        endcase
    end

    // Ratio 2 << code: 2, 4, 8, 16
    assign div_top = 4'((5'h02 << div_sel_q) - 5'h01);

    // Divider counts master ticks and emits one per ratio
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            div_cnt_q    <= 4'h0;
            PWM_CLK_TICK <= 1'b0;
            MASTER_TICK  <= 1'b0;
        end else begin
            MASTER_TICK <= sel_tick;
            if (sel_tick) begin
                if (div_cnt_q >= div_top) begin
                    div_cnt_q    <= 4'h0;
                    PWM_CLK_TICK <= 1'b1;
                end else begin
                    div_cnt_q    <= div_cnt_q + 4'h1;
                    PWM_CLK_TICK <= 1'b0;
                end
            end else begin
                PWM_CLK_TICK <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Frequency scaler
    // ==========================================================
    logic scaled_pulse;   // Scaler pulse, registered inside

    pcs_scaler u_scaler (
        .clk     (CLK_SYS),
        .rst     (SYS_RST),
        .tick    (sel_tick),
        .step    (step_q),
        .min_per (min_per_q),
        .pulse_q (scaled_pulse)
    );

    assign SCALED_PULSE = scaled_pulse;

    // ==========================================================
    // Interrupts
    // ==========================================================
    logic [2:0] ev;        // Event pulses this cycle
    logic       ready_d1;  // Ready of the previous cycle

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ready_d1 <= 1'b0;
        end else begin
            ready_d1 <= ready_q;
        end
    end

    assign ev[PCS_EV_READY] = ready_q && !ready_d1;
    assign ev[PCS_EV_ERROR] = HIRES_FAULT && !error_q;
    assign ev[PCS_EV_PULSE] = scaled_pulse;

    // Set beats clear so no event is lost
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            irq_stat_q <= 3'h0;
            irq_en_q   <= PCS_RST_IRQEN;
        end else begin
            if (req.wr && req.addr == PCS_OFS_IRQCLR) begin
                irq_stat_q <= (irq_stat_q & ~req.wdata[2:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
            if (req.wr && req.addr == PCS_OFS_IRQEN) begin
                irq_en_q <= req.wdata[2:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_q & irq_en_q);
        end
    end

    // ==========================================================
    // Read path, data in the cycle after the strobe
    // ==========================================================
    logic [15:0] clkcon_rd;   // Control image, holes read zero

    assign clkcon_rd = {ready_q, error_q, 5'h00, lock_q, 2'h0,
                        div_sel_q, 2'h0, src_q};

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RDATA <= 16'h0000;
        end else if (req.rd) begin
            unique case (req.addr)
                PCS_OFS_CLKCON:  RDATA <= clkcon_rd;
                PCS_OFS_STEP:    RDATA <= step_q;
                PCS_OFS_MINPER:  RDATA <= min_per_q;
                PCS_OFS_IRQSTAT: RDATA <= {13'h0000, irq_stat_q};
                PCS_OFS_IRQEN:   RDATA <= {13'h0000, irq_en_q};
                PCS_OFS_STATUS:  RDATA <= {13'h0000, src_chg_run_q,
                                           unlock_ok, FULL_RES};
                default:         RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    lock_blocks_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (wr_clkcon && lock_q) |=> $stable(div_sel_q) && $stable(src_q))
        else $error("protected field changed while locked");

    lock_clear_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        ($fell(lock_q)) |-> $past(unlock_ok) && $past(wr_clkcon))
        else $error("lock cleared without unlock sequence");

    full_res_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        FULL_RES |-> $past(ready_q) && !$past(error_q))
        else $error("full resolution without ready");

    error_sticky_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        HIRES_FAULT |=> error_q ##1 !FULL_RES)
        else $error("fault did not set error");

    ready_follow_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        HIRES_CAL_DONE |=> ready_q)
        else $error("ready bit not following calibration");

    holes_zero_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (req.rd && req.addr == PCS_OFS_CLKCON) |=> (RDATA & 16'h3ECC) == 0)
        else $error("unimplemented control bits read nonzero");

    div_ratio_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        PWM_CLK_TICK |-> $past(div_cnt_q) == $past(div_top))
        else $error("divider wrap at wrong count");

    src_sel_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (src_q == PCS_SRC_PRIPLL) |=> MASTER_TICK == $past(SRC_PRIPLL_TICK))
        else $error("wrong master clock source");

    step_write_a: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (req.wr && !lock_q && req.addr == PCS_OFS_STEP)
        |=> step_q == $past(req.wdata))
        else $error("step register not written");

endmodule

// File: sim/pcs_top_test.sv
/*
 * Self-checking bench of the PWM clock control and scaler top.
 * Assumes pcs_pkg is compiled first; the bench drives every port.
 */
module pcs_top_test
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    // ==========================================================
    logic        clk_sys;    // 50 MHz system clock
    logic        sys_rst;    // Sync reset, high
    logic [3:0]  addr;       // Register index
    logic [15:0] wdata;      // Write data
    logic        wr;         // Write strobe
    logic        rd;         // Read strobe
    logic [15:0] rdata;      // Read data
    logic [3:0]  tick;       // Source ticks, bit = source code
    logic        cal_done;   // Fine-edge calibrated
    logic        fault;      // Fine-edge fault
    logic        gen_on;     // Any generator running
    logic        mtick;      // Master tick out
    logic        ptick;      // Divided tick out
    logic        spulse;     // Scaler pulse out
    logic        full_res;   // Full resolution flag
    logic        irq;        // Interrupt level
    logic [15:0] v;          // Scratch read value
    int          n_mismatch; // Failed comparisons
    int          n_compared; // All comparisons
    int          n_mt;       // Master ticks seen
    int          n_pt;       // Divided ticks seen
    int          n_sp;       // Scaler pulses seen

    pcs_top dut_u (
        .CLK_SYS          (clk_sys),
        .SYS_RST          (sys_rst),
        .ADDR             (addr),
        .WDATA            (wdata),
        .WR               (wr),
        .RD               (rd),
        .RDATA            (rdata),
        .SRC_SYSOSC_TICK  (tick[0]),
        .SRC_AUXVCO2_TICK (tick[1]),
        .SRC_PRIPLL_TICK  (tick[2]),
        .SRC_AUXPLL_TICK  (tick[3]),
        .HIRES_CAL_DONE   (cal_done),
        .HIRES_FAULT      (fault),
        .GEN_ANY_ON       (gen_on),
        .MASTER_TICK      (mtick),
        .PWM_CLK_TICK     (ptick),
        .SCALED_PULSE     (spulse),
        .FULL_RES         (full_res),
        .IRQ              (irq)
    );

    // Free-running clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Pulse counters; deltas avoid racing the tasks on resets
    always @(posedge clk_sys) begin
        if (mtick === 1'b1) n_mt++;
        if (ptick === 1'b1) n_pt++;
        if (spulse === 1'b1) n_sp++;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Reset held for 20 edges
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
    endtask

    // One-cycle write strobe
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp,
                          input string what);
        logic [15:0] d;
        reg_rd(a, d);
        check(what, d, exp);
    endtask

    // Read strobe right behind a write, called on the write's last edge
    task automatic rd_next(input logic [3:0] a, input logic [15:0] exp,
                           input string what);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 check(what, rdata, exp);
    endtask

    // Pulse one source n times, then let outputs drain
    task automatic pulse(input int j, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            tick[j] <= 1'b1;
            @(posedge clk_sys);
            tick[j] <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Reset values, width, unmapped and reserved bits, lock
    task automatic t_regs();
        rd_chk(PCS_OFS_CLKCON, PCS_RST_CLKCON, "ctl reset");
        rd_chk(PCS_OFS_MINPER, PCS_RST_MINPER, "minper reset");
        rd_chk(4'hF, 16'h0000, "unmapped");
        reg_wr(PCS_OFS_MINPER, 16'hFFFF);
        rd_chk(PCS_OFS_MINPER, 16'hFFFF, "minper");
        reg_wr(PCS_OFS_STEP, 16'h1234);
        reg_wr(PCS_OFS_CLKCON, 16'hFFFF);
        rd_chk(PCS_OFS_CLKCON, 16'h0133, "ctl ones");
        reg_wr(PCS_OFS_STEP, 16'h5678);
        rd_chk(PCS_OFS_STEP, 16'h1234, "locked step");
        reg_wr(PCS_OFS_CLKCON, 16'h0000);
        rd_chk(PCS_OFS_CLKCON, 16'h0133, "no key");
        // Broken key sequence must not open the lock
        reg_wr(PCS_OFS_UNLOCK, PCS_KEY_FIRST);
        reg_wr(PCS_OFS_UNLOCK, 16'h0001);
        reg_wr(PCS_OFS_UNLOCK, PCS_KEY_SECOND);
        reg_wr(PCS_OFS_CLKCON, 16'h0033);
        rd_chk(PCS_OFS_CLKCON, 16'h0133, "bad key");
        reg_wr(PCS_OFS_UNLOCK, PCS_KEY_FIRST);
        reg_wr(PCS_OFS_UNLOCK, PCS_KEY_SECOND);
        // Reads leave the open window alone
        rd_chk(PCS_OFS_STATUS, 16'h0002, "window open");
        reg_wr(PCS_OFS_CLKCON, 16'h0033);
        rd_chk(PCS_OFS_CLKCON, 16'h0033, "unlocked");
        reg_wr(PCS_OFS_STEP, 16'h5678);
        rd_chk(PCS_OFS_STEP, 16'h5678, "open step");
    endtask

    // Every ratio over 32 ticks, a multiple of all ratios
    task automatic t_div();
        int bp;
        int bm;
        for (int d = 0; d < 4; d++) begin
            reg_wr(PCS_OFS_CLKCON, 16'(d << PCS_POS_DIV));
            bp = n_pt;
            bm = n_mt;
            pulse(0, 32);
            check("div ticks", 16'(n_pt - bp), 16'(32 >> (d + 1)));
            check("master ticks", 16'(n_mt - bm), 16'h0020);
        end
    endtask

    // Only the selected source reaches the master tick
    task automatic t_src();
        int b;
        for (int s = 0; s < 4; s++) begin
            reg_wr(PCS_OFS_CLKCON, 16'(s));
            // Change flag lives one cycle, so read it back to back
            rd_next(PCS_OFS_STATUS, (s != 0) ? 16'h0004 : 16'h0000,
                    "src change flag");
            for (int j = 0; j < 4; j++) begin
                b = n_mt;
                pulse(j, 3);
                check("src ticks", 16'(n_mt - b),
                      (j == s) ? 16'h0003 : 16'h0000);
            end
        end
    endtask

    // Step 3 against period 4; equal sum gives no pulse
    task automatic t_scale();
        int acc;
        int exp;
        int b;
        acc = 0;
        exp = 0;
        reg_wr(PCS_OFS_CLKCON, 16'h0000);
        reg_wr(PCS_OFS_MINPER, 16'h0004);
        reg_wr(PCS_OFS_STEP, 16'h0003);
        for (int i = 0; i < 8; i++) begin
            acc += 3;
            if (acc > 4) begin
                exp++;
                acc -= 4;
            end
        end
        b = n_sp;
        pulse(0, 8);
        check("scaled", 16'(n_sp - b), 16'(exp));
    endtask

    // Ready, sticky error, resolution and interrupt path
    task automatic t_hires();
        check("full res idle", {15'h0, full_res}, 16'h0000);
        reg_wr(PCS_OFS_IRQEN, 16'h0002);
        cal_done <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reg_rd(PCS_OFS_CLKCON, v);
        check("ready", v & 16'hC000, 16'h8000);
        check("full res", {15'h0, full_res}, 16'h0001);
        check("irq masked", {15'h0, irq}, 16'h0000);
        @(posedge clk_sys);
        fault <= 1'b1;
        @(posedge clk_sys);
        fault <= 1'b0;
        repeat (3) @(posedge clk_sys);
        reg_rd(PCS_OFS_CLKCON, v);
        check("error", v & 16'hC000, 16'hC000);
        check("reduced res", {15'h0, full_res}, 16'h0000);
        check("irq set", {15'h0, irq}, 16'h0001);
        // Scaler pulses of the previous scenario left bit 2 set
        rd_chk(PCS_OFS_IRQSTAT, 16'h0007, "irq status");
        reg_wr(PCS_OFS_IRQCLR, 16'h0007);
        repeat (2) @(posedge clk_sys);
        check("irq clear", {15'h0, irq}, 16'h0000);
        rd_chk(PCS_OFS_IRQSTAT, 16'h0000, "status clear");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        n_mismatch = 0;
        n_compared = 0;
        n_mt = 0;
        n_pt = 0;
        n_sp = 0;
        sys_rst = 1'b1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        tick = 4'h0;
        cal_done = 1'b0;
        fault = 1'b0;
        gen_on = 1'b0;
        do_reset();
        t_regs();
        // Fresh state so divider and accumulator start at zero
        do_reset();
        t_div();
        gen_on <= 1'b1;
        t_src();
        gen_on <= 1'b0;
        t_scale();
        t_hires();
        stop_test();
    end

    // Hang guard: well above the longest expected run
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        stop_test();
    end
endmodule
